// *** ivm_vector_map.sv ***
// interrupt vector map: source mapping, pending flags, vector offer and lookup
`timescale 1ns/1ps
`default_nettype none
module ivm_vector_map (
  // clock, reset, enable
  input  wire logic                 CLK_IN,
  input  wire logic                 RESETN_IN,
  input  wire logic                 CE_IN,
  // core trap events, one-cycle pulses
  input  wire logic                 SOFT_CALL_IN,
  input  wire logic [2:0]           SOFT_CALL_IDX_IN,
  input  wire logic                 TRAP_NINE_IN,
  input  wire logic                 UNDEF_INSN_IN,
  // pins, asynchronous levels
  input  wire logic                 NMI_IN,
  input  wire logic [4:0]           EXT_REQ_LO_IN,
  input  wire logic [1:0]           EXT_REQ_HI_IN,
  // peripheral events, one-cycle pulses
  input  wire ivm_pkg::ivm_src_t    PERIPH_REQ_IN,
  // DMA completion
  input  wire logic                 DMA_DONE_IN,
  input  wire logic [7:0]           DMA_VEC_IN,
  // core fetch handshake
  input  wire logic                 ACK_IN,
  output var  ivm_pkg::ivm_vec_t    VEC_OFFER_OUT,
  // attribute lookup
  input  wire logic [7:0]           LOOKUP_VEC_IN,
  output var  ivm_pkg::ivm_vec_t    LOOKUP_OUT,
  // status
  output logic [143:0]              PENDING_OUT,
  output logic                      DMA_REJECT_OUT
);

  // ==================================================================
  // state
  typedef struct packed {
    ivm_pkg::ivm_fsm_t fsm;
    logic [7:0]        pin_prev;
    ivm_pkg::ivm_vec_t offer;
    ivm_pkg::ivm_vec_t lookup;
    logic              dma_reject;
  } ivm_state_t;

  ivm_state_t st_q;
  ivm_state_t st_d;

  logic [7:0]                        pin_sync;
  logic [7:0]                        pin_rise;
  logic [ivm_pkg::IVM_NUM_VEC-1:0]   pend;
  logic [ivm_pkg::IVM_NUM_VEC-1:0]   set_raw;
  logic [ivm_pkg::IVM_NUM_VEC-1:0]   set_vec;
  logic [ivm_pkg::IVM_NUM_VEC-1:0]   clr_vec;
  logic                              any_pend;
  logic [7:0]                        win_num;
  logic                              dma_ok;
  logic                              dma_hit;

  // ==================================================================
  // pin synchronisers: nmi in bit 7, high externals in 6:5, low in 4:0
  ivm_sync #(
    .W (8)
  ) u_pin_sync (
    .clk_in    (CLK_IN),
    .resetn_in (RESETN_IN),
    .ce_in     (CE_IN),
    .async_in  ({NMI_IN, EXT_REQ_HI_IN, EXT_REQ_LO_IN}),
    .sync_out  (pin_sync)
  );

  // rising edges of the synchronised pins raise a request
  assign pin_rise = pin_sync & ~st_q.pin_prev;

  // ==================================================================
  // source to vector mapping
  always_comb begin
    set_raw = '0;
    // software calls select one of eight vectors
    if (SOFT_CALL_IN) begin
      set_raw[int'(ivm_pkg::IVM_V_CALL0) + int'(SOFT_CALL_IDX_IN)] = 1'b1;
    end
    // core traps and the non-maskable pin
    set_raw[ivm_pkg::IVM_V_TRAP9] = TRAP_NINE_IN;
    set_raw[ivm_pkg::IVM_V_UNDEF] = UNDEF_INSN_IN;
    set_raw[ivm_pkg::IVM_V_NMI]   = pin_rise[7];
    // system timers and low-voltage event
    set_raw[int'(ivm_pkg::IVM_V_DELAY) + 0] = PERIPH_REQ_IN.delayed_request;
    set_raw[int'(ivm_pkg::IVM_V_DELAY) + 1] = PERIPH_REQ_IN.rc_oscillator_tick;
    set_raw[int'(ivm_pkg::IVM_V_DELAY) + 2] = PERIPH_REQ_IN.main_oscillator_tick;
    set_raw[int'(ivm_pkg::IVM_V_DELAY) + 3] = PERIPH_REQ_IN.sub_oscillator_tick;
    set_raw[int'(ivm_pkg::IVM_V_DELAY) + 4] = PERIPH_REQ_IN.low_voltage_event;
    // external requests, input 5 has no vector
    for (int i = 0; i < 5; i++) begin
      set_raw[int'(ivm_pkg::IVM_V_EXT_LO) + i] = pin_rise[i];
    end
    for (int i = 0; i < 2; i++) begin
      set_raw[int'(ivm_pkg::IVM_V_EXT_HI) + i] = pin_rise[5 + i];
    end
    // can controller
    set_raw[ivm_pkg::IVM_V_CAN] = PERIPH_REQ_IN.can_controller_zero;
    // pulse generators
    for (int i = 0; i < 4; i++) begin
      set_raw[int'(ivm_pkg::IVM_V_PPG) + i] = PERIPH_REQ_IN.pulse_generator[i];
    end
    // reload timers 1, 2, 6
    set_raw[int'(ivm_pkg::IVM_V_RELOAD_TIMER_1) + 0] = PERIPH_REQ_IN.reload_timer[0];
    set_raw[int'(ivm_pkg::IVM_V_RELOAD_TIMER_1) + 1] = PERIPH_REQ_IN.reload_timer[1];
    set_raw[ivm_pkg::IVM_V_RLT6]           = PERIPH_REQ_IN.reload_timer[2];
    // capture units 0, 1, 4, 5
    for (int i = 0; i < 2; i++) begin
      set_raw[int'(ivm_pkg::IVM_V_INPUT_CAPTURE_0) + i] = PERIPH_REQ_IN.input_capture[i];
      set_raw[int'(ivm_pkg::IVM_V_ICU4) + i] = PERIPH_REQ_IN.input_capture[2 + i];
    end
    // free-running timers
    for (int i = 0; i < 2; i++) begin
      set_raw[int'(ivm_pkg::IVM_V_FRT) + i] = PERIPH_REQ_IN.free_running_timer[i];
    end
    // calendar, calibrator, sound
    set_raw[int'(ivm_pkg::IVM_V_CALENDAR) + 0] = PERIPH_REQ_IN.calendar_clock;
    set_raw[int'(ivm_pkg::IVM_V_CALENDAR) + 1] = PERIPH_REQ_IN.clock_calibrator;
    set_raw[int'(ivm_pkg::IVM_V_CALENDAR) + 2] = PERIPH_REQ_IN.sound_generator_zero;
    // two-wire port and converter completion
    set_raw[ivm_pkg::IVM_V_TWI] = PERIPH_REQ_IN.two_wire_port_0;
    set_raw[ivm_pkg::IVM_V_ADC] = PERIPH_REQ_IN.analog_converter_0;
    // lin serial: rx0, tx0, rx1, tx1
    for (int i = 0; i < 4; i++) begin
      set_raw[int'(ivm_pkg::IVM_V_LIN) + i] = PERIPH_REQ_IN.lin_serial[i];
    end
    // flash and converter monitor events
    set_raw[ivm_pkg::IVM_V_FLASH] = PERIPH_REQ_IN.flash_bank_a_event;
    set_raw[ivm_pkg::IVM_V_RANGE] = PERIPH_REQ_IN.converter_range_compare;
    set_raw[ivm_pkg::IVM_V_PULSE] = PERIPH_REQ_IN.converter_pulse_detect;
  end

  // reserved vectors can never become pending
  assign set_vec = set_raw & ivm_pkg::IVM_USED_MASK;

  // ==================================================================
  // clear sources: core acceptance and DMA completion
  assign dma_ok  = DMA_VEC_IN < 8'(ivm_pkg::IVM_NUM_VEC);
  assign dma_hit = DMA_DONE_IN && dma_ok && ivm_pkg::IVM_DMA_MASK[DMA_VEC_IN];

  always_comb begin
    clr_vec = '0;
    // accepted vector leaves the pending set
    if (ACK_IN && (st_q.fsm == ivm_pkg::IVM_OFFER)) begin
      clr_vec[st_q.offer.num] = 1'b1;
    end
    // DMA service clears only clearable vectors
    if (dma_hit) begin
      clr_vec[DMA_VEC_IN] = 1'b1;
    end
  end

  // ==================================================================
  // pending flags, reset vector pending out of reset
  ivm_pend #(
    .W   (ivm_pkg::IVM_NUM_VEC),
    .RST (ivm_pkg::IVM_PEND_RST)
  ) u_pend (
    .clk_in    (CLK_IN),
    .resetn_in (RESETN_IN),
    .ce_in     (CE_IN),
    .set_in    (set_vec),
    .clr_in    (clr_vec),
    .pend_out  (pend)
  );

  // ==================================================================
  // lowest vector number wins
  always_comb begin
    any_pend = 1'b0;
    win_num  = 8'h00;
    for (int i = ivm_pkg::IVM_NUM_VEC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        any_pend = 1'b1;
        win_num  = 8'(i);
      end
    end
  end

  // ==================================================================
  // next state: offer stays frozen until accepted or withdrawn
  always_comb begin
    st_d            = st_q;
    st_d.pin_prev   = pin_sync;
    st_d.dma_reject = DMA_DONE_IN && !dma_hit; // non-clearable target ignored
    st_d.lookup     = ivm_pkg::ivm_attr(LOOKUP_VEC_IN);
    unique case (st_q.fsm)
      ivm_pkg::IVM_IDLE: begin
        if (any_pend) begin
          st_d.offer = ivm_pkg::ivm_attr(win_num);
          st_d.fsm   = ivm_pkg::IVM_OFFER;
        end else begin
          st_d.offer = '0;
        end
      end
      ivm_pkg::IVM_OFFER: begin
        // accepted, or cleared by DMA before acceptance
        if (ACK_IN || !pend[st_q.offer.num]) begin
          st_d.offer = '0;
          st_d.fsm   = ivm_pkg::IVM_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_q <= '0;
    end else if (CE_IN) begin
      st_q <= st_d;
    end
  end

  // ==================================================================
  // outputs
  assign VEC_OFFER_OUT  = st_q.offer;
  assign LOOKUP_OUT     = st_q.lookup;
  assign PENDING_OUT    = pend;
  assign DMA_REJECT_OUT = st_q.dma_reject;

endmodule : ivm_vector_map
`default_nettype wire

// *** ivm_pkg.sv ***
// package: vector numbers, table layout, types and attribute lookup for the vector map
// Functional notes
// - vectors 0-7 software calls, no DMA, no index
// - reset entry from vector 8, fixed
// - trap nine vector 9, undefined opcode 10
// - non-maskable pin routes to vector 11
// - vectors 12-16 system timers, index equals vector
// - external 0-4 to 17-21, 6-7 to 23-24
// - can controller on vector 33, not DMA
// - pulse generators 0-3 on vectors 38-41
// - reload timers 1,2,6 on 59,60,64
// - capture units 0,1,4,5 on 65,66,69,70
// - free-running timers on vectors 89 and 90
// - calendar, calibrator, sound on 93-95, no DMA
// - two-wire port 96, converter done 98
// - lin serial rx/tx on vectors 101-104
// - flash bank event on vector 133, DMA
// - range compare 139, pulse detect 140, no DMA
package ivm_pkg;

  // ==================================================================
  // table layout
  localparam int unsigned IVM_NUM_VEC   = 144;
  localparam logic [9:0]  IVM_TABLE_TOP = 10'h3fc;
  localparam logic [7:0]  IVM_ICR_FIRST = 8'h0c;

  // ==================================================================
  // vector numbers
  localparam logic [7:0] IVM_V_CALL0   = 8'h00;
  localparam logic [7:0] IVM_V_RESET   = 8'h08;
  localparam logic [7:0] IVM_V_TRAP9   = 8'h09;
  localparam logic [7:0] IVM_V_UNDEF   = 8'h0a;
  localparam logic [7:0] IVM_V_NMI     = 8'h0b;
  localparam logic [7:0] IVM_V_DELAY   = 8'h0c;
  localparam logic [7:0] IVM_V_EXT_LO  = 8'h11;
  localparam logic [7:0] IVM_V_EXT_HI  = 8'h17;
  localparam logic [7:0] IVM_V_CAN     = 8'h21;
  localparam logic [7:0] IVM_V_PPG     = 8'h26;
  localparam logic [7:0] IVM_V_RELOAD_TIMER_1    = 8'h3b;
  localparam logic [7:0] IVM_V_RLT2    = 8'h3c;
  localparam logic [7:0] IVM_V_RLT6    = 8'h40;
  localparam logic [7:0] IVM_V_INPUT_CAPTURE_0    = 8'h41;
  localparam logic [7:0] IVM_V_ICU4    = 8'h45;
  localparam logic [7:0] IVM_V_FRT     = 8'h59;
  localparam logic [7:0] IVM_V_CALENDAR = 8'h5d;
  localparam logic [7:0] IVM_V_TWI     = 8'h60;
  localparam logic [7:0] IVM_V_ADC     = 8'h62;
  localparam logic [7:0] IVM_V_LIN     = 8'h65;
  localparam logic [7:0] IVM_V_FLASH   = 8'h85;
  localparam logic [7:0] IVM_V_RANGE   = 8'h8b;
  localparam logic [7:0] IVM_V_PULSE   = 8'h8c;

  // ==================================================================
  // masks: DMA-clearable vectors, vectors that own a source, pending value at reset
  localparam logic [IVM_NUM_VEC-1:0] IVM_DMA_MASK =
    (144'h1f << IVM_V_EXT_LO) | (144'h3 << IVM_V_EXT_HI) | (144'hf << IVM_V_PPG)
    | (144'h3 << IVM_V_RELOAD_TIMER_1) | (144'h1 << IVM_V_RLT6) | (144'h3 << IVM_V_INPUT_CAPTURE_0)
    | (144'h3 << IVM_V_ICU4) | (144'h3 << IVM_V_FRT) | (144'h5 << IVM_V_TWI)
    | (144'hf << IVM_V_LIN) | (144'h1 << IVM_V_FLASH);
  localparam logic [IVM_NUM_VEC-1:0] IVM_USED_MASK = IVM_DMA_MASK
    | (144'h1ffff << IVM_V_CALL0) | (144'h1 << IVM_V_CAN)
    | (144'h7 << IVM_V_CALENDAR) | (144'h3 << IVM_V_RANGE);
  localparam logic [IVM_NUM_VEC-1:0] IVM_PEND_RST = 144'h1 << IVM_V_RESET;

  // ==================================================================
  // types
  typedef enum logic {IVM_IDLE, IVM_OFFER} ivm_fsm_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] num;
    logic [9:0] offset;
    logic       icr_valid;
    logic [7:0] icr_idx;
    logic       dma_clr;
  } ivm_vec_t;

  typedef struct packed {
    logic       delayed_request;
    logic       rc_oscillator_tick;
    logic       main_oscillator_tick;
    logic       sub_oscillator_tick;
    logic       low_voltage_event;
    logic       can_controller_zero;
    logic [3:0] pulse_generator;
    logic [2:0] reload_timer;
    logic [3:0] input_capture;
    logic [1:0] free_running_timer;
    logic       calendar_clock;
    logic       clock_calibrator;
    logic       sound_generator_zero;
    logic       two_wire_port_0;
    logic       analog_converter_0;
    logic [3:0] lin_serial;
    logic       flash_bank_a_event;
    logic       converter_range_compare;
    logic       converter_pulse_detect;
  } ivm_src_t;

  // attributes of one vector number
  function automatic ivm_vec_t ivm_attr(input logic [7:0] v);
    ivm_vec_t a;
    a           = '0;
    a.num       = v;
    if (v < 8'(IVM_NUM_VEC)) begin
      a.valid     = IVM_USED_MASK[v];
      a.offset    = IVM_TABLE_TOP - {v, 2'b00};
      a.icr_valid = (v >= IVM_ICR_FIRST);
      a.icr_idx   = a.icr_valid ? v : 8'h00;
      a.dma_clr   = IVM_DMA_MASK[v];
    end
    return a;
  endfunction : ivm_attr

endpackage : ivm_pkg

// *** ivm_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ivm_sync #(
  parameter int unsigned W = 1
) (
  // clock, reset, enable
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic         ce_in,
  // pins and synchronised levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ivm_sync_st_t;

  ivm_sync_st_t st_q;
  ivm_sync_st_t st_d;

  // first stage feeds only the second
  always_comb begin
    st_d        = st_q;
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  // state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= '0;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stable;

endmodule : ivm_sync
`default_nettype wire

// *** ivm_pend.sv ***
// bank of sticky pending flags, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module ivm_pend #(
  parameter int unsigned             W   = 1,
  parameter logic        [W-1:0]     RST = '0
) (
  // clock, reset, enable
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic         ce_in,
  // set and clear strobes
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  // pending flags
  output logic      [W-1:0] pend_out
);

  typedef struct packed {
    logic [W-1:0] pend;
  } ivm_pend_st_t;

  ivm_pend_st_t st_q;
  ivm_pend_st_t st_d;

  // a set in the clearing cycle is kept
  always_comb begin
    st_d      = st_q;
    st_d.pend = (st_q.pend & ~clr_in) | set_in;
  end

  // state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= RST;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign pend_out = st_q.pend;

endmodule : ivm_pend
`default_nettype wire

// *** ivm_vector_map_asserts.sv ***
// checker of the vector map port behaviour
`timescale 1ns/1ps
`default_nettype none
module ivm_vector_map_asserts (
  // clock and reset
  input wire logic              CLK_IN,
  input wire logic              RESETN_IN,
  // clock enable, core and DMA requests, lookup vector
  input wire logic              CE_IN,
  input wire logic              DMA_DONE_IN,
  input wire logic [7:0]        DMA_VEC_IN,
  input wire logic              ACK_IN,
  input wire logic [7:0]        LOOKUP_VEC_IN,
  // map outputs
  input wire ivm_pkg::ivm_vec_t VEC_OFFER_OUT,
  input wire ivm_pkg::ivm_vec_t LOOKUP_OUT,
  input wire logic [143:0]      PENDING_OUT,
  input wire logic              DMA_REJECT_OUT
);
  // ========
  // properties, one clock domain
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  reset_vector_a: assert property (
    $rose(RESETN_IN) |=> VEC_OFFER_OUT.valid && VEC_OFFER_OUT.num == 8'h08)
    else $error("reset vector not offered first");
  offer_attr_a: assert property (
    VEC_OFFER_OUT.valid |-> VEC_OFFER_OUT.offset == 10'h3fc - {VEC_OFFER_OUT.num, 2'b00}
    && VEC_OFFER_OUT.dma_clr == ivm_pkg::IVM_DMA_MASK[VEC_OFFER_OUT.num])
    else $error("offered vector attributes wrong");
  lookup_attr_a: assert property (
    CE_IN && LOOKUP_VEC_IN < 8'h90 |=> LOOKUP_OUT.offset == 10'h3fc - {$past(LOOKUP_VEC_IN), 2'b00}
    && LOOKUP_OUT.valid == ivm_pkg::IVM_USED_MASK[$past(LOOKUP_VEC_IN)])
    else $error("lookup attributes wrong");
  reserved_silent_a: assert property (
    (PENDING_OUT & ~ivm_pkg::IVM_USED_MASK) == 144'h0)
    else $error("reserved vector pending");
  dma_reject_a: assert property (
    CE_IN && DMA_DONE_IN |=> DMA_REJECT_OUT
    == !($past(DMA_VEC_IN) < 8'h90 && ivm_pkg::IVM_DMA_MASK[$past(DMA_VEC_IN)]))
    else $error("DMA reject pulse wrong");
  offer_lowest_a: assert property (
    $rose(VEC_OFFER_OUT.valid) |-> $past(PENDING_OUT) << (144 - VEC_OFFER_OUT.num) == 144'h0)
    else $error("offer is not the lowest pending");
  offer_hold_a: assert property (
    VEC_OFFER_OUT.valid && !ACK_IN && !DMA_DONE_IN && !$past(DMA_DONE_IN) && CE_IN
    |=> VEC_OFFER_OUT.valid && $stable(VEC_OFFER_OUT.num))
    else $error("offer changed without acknowledge");
  ack_drop_a: assert property (
    VEC_OFFER_OUT.valid && ACK_IN && CE_IN |=> !VEC_OFFER_OUT.valid)
    else $error("offer stands after acknowledge");
endmodule : ivm_vector_map_asserts

bind ivm_vector_map ivm_vector_map_asserts u_ivm_vector_map_asserts (
  .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .CE_IN(CE_IN), .DMA_DONE_IN(DMA_DONE_IN),
  .DMA_VEC_IN(DMA_VEC_IN), .ACK_IN(ACK_IN), .LOOKUP_VEC_IN(LOOKUP_VEC_IN),
  .VEC_OFFER_OUT(VEC_OFFER_OUT), .LOOKUP_OUT(LOOKUP_OUT), .PENDING_OUT(PENDING_OUT),
  .DMA_REJECT_OUT(DMA_REJECT_OUT));
`default_nettype wire

// *** ivm_core_model.sv ***
// behavioural core that accepts offered vectors after a set wait
`timescale 1ns/1ps
`default_nettype none
module ivm_core_model (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  // bench control
  input  wire logic              en_in,
  input  wire logic [3:0]        delay_in,
  // fetch handshake
  input  wire ivm_pkg::ivm_vec_t offer_in,
  output logic                   ack_out,
  // accepted vector report
  output logic                   took_out,
  output var ivm_pkg::ivm_vec_t  took_vec_out
);
  logic [3:0] wait_q;

  // wait, then one-cycle acknowledge while the offer stands
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wait_q <= 4'h0;
      ack_out <= 1'b0;
      took_out <= 1'b0;
      took_vec_out <= '0;
    end else begin
      took_out <= ack_out & offer_in.valid;
      ack_out <= 1'b0;
      if (ack_out) begin
        took_vec_out <= offer_in;
        wait_q <= 4'h0;
      end else if (offer_in.valid && en_in) begin
        if (wait_q == delay_in) begin
          ack_out <= 1'b1;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule : ivm_core_model
`default_nettype wire

// *** tb_interrupt_vector_map.sv ***
// testbench of the vector map with a modelled core
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_vector_map;
  // ========
  // stimulus and observed signals
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              call = 1'b0;
  logic [2:0]        call_idx = 3'h0;
  logic              trap = 1'b0;
  logic              undef = 1'b0;
  logic              ce = 1'b1;
  logic [7:0]        pins = 8'h00;
  ivm_pkg::ivm_src_t periph = '0;
  logic              dma_done = 1'b0;
  logic [7:0]        dma_vec = 8'h00;
  logic [7:0]        look_vec = 8'h00;
  logic              core_en = 1'b1;
  logic [3:0]        core_dly = 4'h0;
  logic              ack;
  logic              took;
  logic              rej;
  logic [143:0]      pend;
  logic [143:0]      exp_pend = '0;
  ivm_pkg::ivm_vec_t offer;
  ivm_pkg::ivm_vec_t look;
  ivm_pkg::ivm_vec_t took_vec;
  int                err_count = 0;
  int                checks_done = 0;

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  ivm_vector_map u_ivm_vector_map (.CLK_IN(clk), .RESETN_IN(rst_n), .CE_IN(ce),
    .SOFT_CALL_IN(call), .SOFT_CALL_IDX_IN(call_idx), .TRAP_NINE_IN(trap),
    .UNDEF_INSN_IN(undef), .NMI_IN(pins[0]), .EXT_REQ_LO_IN(pins[5:1]),
    .EXT_REQ_HI_IN(pins[7:6]), .PERIPH_REQ_IN(periph), .DMA_DONE_IN(dma_done),
    .DMA_VEC_IN(dma_vec), .ACK_IN(ack), .VEC_OFFER_OUT(offer), .LOOKUP_VEC_IN(look_vec),
    .LOOKUP_OUT(look), .PENDING_OUT(pend), .DMA_REJECT_OUT(rej));
  ivm_core_model u_ivm_core_model (.clk_in(clk), .resetn_in(rst_n), .en_in(core_en),
    .delay_in(core_dly), .offer_in(offer), .ack_out(ack), .took_out(took),
    .took_vec_out(took_vec));

  // expected attributes of one vector number
  function automatic ivm_pkg::ivm_vec_t exp_vec(input logic [7:0] v);
    ivm_pkg::ivm_vec_t e;
    e = '0;
    e.num = v;
    if (v < 8'h90) begin
      e.offset = 10'h3fc - {v, 2'b00};
      e.icr_valid = (v > 8'h0b);
      e.icr_idx = e.icr_valid ? v : 8'h00;
      case (v) inside
        [0:16], 33, [93:95], 139, 140: e.valid = 1'b1;
        [17:21], 23, 24, [38:41], 59, 60, [64:66], 69, 70, 89, 90, 96, 98, [101:104], 133: begin
          e.valid = 1'b1;
          e.dma_clr = 1'b1;
        end
        default: e.valid = 1'b0;
      endcase
    end
    return e;
  endfunction : exp_vec

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string what, input logic [143:0] exp, input logic [143:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done;
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // wait for the core to accept, then compare the vector it took
  task automatic wait_took(input logic [7:0] v);
    int n;
    n = 0;
    while (took !== 1'b1 && n < 50) begin
      tick;
      n++;
    end
    if (took !== 1'b1) begin
      err_count++;
      test_done;
    end
    chk("accepted vector", 144'(exp_vec(v)), 144'(took_vec));
    tick;
  endtask : wait_took

  // reset vector offered first, taken like any other
  task automatic t_reset;
    tick;
    chk("reset offer", 144'(exp_vec(8'h08)), 144'(offer));
    wait_took(8'h08);
    chk("pending after reset", 144'h0, pend);
  endtask : t_reset

  // every vector number and a few beyond the table
  task automatic t_lookup;
    for (int v = 0; v < 150; v++) begin
      look_vec = 8'(v);
      tick;
      chk("lookup", 144'(exp_vec(8'(v))), 144'(look));
    end
  endtask : t_lookup

  // raise every source alone with the core stalled, each must land on its own vector
  task automatic t_raise;
    logic [7:0]        src_vec [31];
    ivm_pkg::ivm_vec_t e;
    // vector of each source bit, lowest struct bit first
    src_vec = '{8'h8c, 8'h8b, 8'h85, 8'h65, 8'h66, 8'h67, 8'h68, 8'h62, 8'h60, 8'h5f, 8'h5e,
      8'h5d, 8'h59, 8'h5a, 8'h41, 8'h42, 8'h45, 8'h46, 8'h3b, 8'h3c, 8'h40, 8'h26, 8'h27,
      8'h28, 8'h29, 8'h21, 8'h10, 8'h0f, 8'h0e, 8'h0d, 8'h0c};
    core_en = 1'b0;
    // software calls, one index per cycle
    call = 1'b1;
    for (int i = 0; i < 8; i++) begin
      call_idx = 3'(i);
      tick;
      exp_pend[i] = 1'b1;
      chk("pending after call", exp_pend, pend);
    end
    call = 1'b0;
    // core traps, each alone
    trap = 1'b1;
    tick;
    trap = 1'b0;
    exp_pend[9] = 1'b1;
    chk("pending after trap nine", exp_pend, pend);
    undef = 1'b1;
    tick;
    undef = 1'b0;
    exp_pend[10] = 1'b1;
    chk("pending after undefined", exp_pend, pend);
    // pins one at a time: two sync stages, then the edge detector
    for (int i = 0; i < 8; i++) begin
      pins[i] = 1'b1;
      repeat (3) tick;
      exp_pend[(i == 0) ? 11 : ((i < 6) ? 16 + i : 17 + i)] = 1'b1;
      chk("pending after pin", exp_pend, pend);
    end
    // nothing lands while the clock enable is low
    ce = 1'b0;
    periph = ivm_pkg::ivm_src_t'(31'h1);
    tick;
    chk("pending while frozen", exp_pend, pend);
    ce = 1'b1;
    // peripheral sources one at a time
    foreach (src_vec[i]) begin
      periph = ivm_pkg::ivm_src_t'(31'h1 << i);
      tick;
      exp_pend[src_vec[i]] = 1'b1;
      chk("pending after source", exp_pend, pend);
    end
    periph = '0;
    tick;
    for (int v = 0; v < 144; v++) begin
      e = exp_vec(8'(v));
      exp_pend[v] = e.valid && v != 8;
    end
    chk("pending after raise", exp_pend, pend);
  endtask : t_raise

  // back-to-back DMA completions, clearable and not
  task automatic t_dma;
    logic [7:0]        list [5];
    ivm_pkg::ivm_vec_t e;
    list = '{8'h11, 8'h21, 8'h16, 8'hc8, 8'h85};
    dma_done = 1'b1;
    foreach (list[i]) begin
      dma_vec = list[i];
      e = exp_vec(list[i]);
      tick;
      if (e.dma_clr) begin
        exp_pend[list[i]] = 1'b0;
      end
      chk("reject", 144'(!e.dma_clr), 144'(rej));
      chk("pending after DMA", exp_pend, pend);
    end
    dma_done = 1'b0;
    tick;
    chk("reject after DMA", 144'h0, 144'(rej));
  endtask : t_dma

  // a stalled offer is withdrawn once DMA clears its vector
  task automatic t_withdraw;
    core_en = 1'b0;
    periph = ivm_pkg::ivm_src_t'(31'h1 << 21);
    tick;
    periph = '0;
    tick;
    chk("offer before DMA", 144'(exp_vec(8'h26)), 144'(offer));
    dma_done = 1'b1;
    dma_vec = 8'h26;
    tick;
    dma_done = 1'b0;
    chk("pending after DMA clear", 144'h0, pend);
    tick;
    chk("offer after DMA clear", 144'h0, 144'(offer));
  endtask : t_withdraw

  // slow core drains all pending in ascending order
  task automatic t_drain;
    core_dly = 4'h2;
    core_en = 1'b1;
    for (int v = 0; v < 144; v++) begin
      if (exp_pend[v]) begin
        wait_took(8'(v));
      end
    end
    chk("pending after drain", 144'h0, pend);
  endtask : t_drain

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_lookup;
    t_raise;
    t_dma;
    t_drain;
    t_withdraw;
    test_done;
  end
endmodule : tb_interrupt_vector_map
`default_nettype wire
